/* File: fsp_consts.svh */
// Constants of the flash self-program sequencer: offsets, fields, resets, timing.
// Included by the package, the sequencer and the checker; holds definitions only.
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// Register indices on the plain register port
`define FSP_ADDR_W 3
`define FSP_OFS_PTR_LOW 3'h0
`define FSP_OFS_PTR_HIGH 3'h1
`define FSP_OFS_PTR_UPPER 3'h2
`define FSP_OFS_LATCH 3'h3
`define FSP_OFS_CTRL 3'h4
`define FSP_OFS_KEY 3'h5

// Control register fields
`define FSP_CTRL_CONFIG_SPACE_SELECT 6
`define FSP_CTRL_ERASE 4
`define FSP_CTRL_ABORT 3
`define FSP_CTRL_WRITE_ENABLE_BIT 2
`define FSP_CTRL_START 1

// Pointer and storage geometry
`define FSP_PTR_W 22
`define FSP_HOLD_N 16
`define FSP_HOLD_AW 4
`define FSP_ROW_LSB 6
`define FSP_BLK_LSB 4

// Values
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa
`define FSP_HOLD_RST 8'hff
`define FSP_BYTE_RST 8'h00

// Timing
`define FSP_CLK_PERIOD_NS 100
`define FSP_LONG_WRITE_NS 2000000
`define FSP_LONG_WRITE_CYC (`FSP_LONG_WRITE_NS / `FSP_CLK_PERIOD_NS)

`endif

/* File: fsp_pkg.sv */
// Types of the flash self-program sequencer.
// Relies on fsp_consts.svh for the pointer width.
`include "fsp_consts.svh"

package fsp_pkg;

  typedef enum logic [1:0] {
    FSP_PTR_KEEP = 2'h0,
    FSP_PTR_POST_INC = 2'h1,
    FSP_PTR_POST_DEC = 2'h2,
    FSP_PTR_PRE_INC = 2'h3
  } fsp_ptr_mode_t;

  typedef enum logic {
    FSP_ST_IDLE = 1'b0,
    FSP_ST_LONG = 1'b1
  } fsp_state_t;

  typedef struct packed {
    logic go;
    logic erase;
    logic cfg;
    logic [`FSP_PTR_W-1:0] addr;
  } fsp_flash_cmd_t;

  typedef struct packed {
    logic en;
    logic [`FSP_PTR_W-1:0] addr;
  } fsp_flash_rd_t;

endpackage : fsp_pkg

/* File: fsp_sequencer.sv */
// Flash self-program sequencer: table pointer, byte latch, holding
// registers, unlock key check and timed row erase / block program.
// Assumes a flash array that answers a read one cycle after its enable
// and clears bits only on program; core table ops arrive on clk.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.svh"

module fsp_sequencer
  import fsp_pkg::*;
#(
  parameter int LONG_CYCLES = `FSP_LONG_WRITE_CYC,
  parameter int TMR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [`FSP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core table operations
  input wire logic tbl_rd_req,
  input wire logic tbl_wr_req,
  input wire logic [1:0] tbl_mode,
  output logic cpu_stall,
  // Flash read side
  output fsp_flash_rd_t flash_rd,
  input wire logic [15:0] flash_rdata,
  // Flash long write side
  output fsp_flash_cmd_t flash_cmd,
  output logic [8*`FSP_HOLD_N-1:0] flash_prog_data,
  output logic [`FSP_HOLD_N-1:0] flash_prog_keep
);

  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(LONG_CYCLES - 1);

  if (TMR_W < 1 || TMR_W > 30) begin : g_bad_tmr
    $error("TMR_W out of range");
  end
  if (LONG_CYCLES < 1 || LONG_CYCLES > (1 << TMR_W)) begin : g_bad_cycles
    $error("LONG_CYCLES does not fit the timer");
  end

  // State
  logic [`FSP_PTR_W-1:0] ptr_r, ptr_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic [7:0] hold_r [`FSP_HOLD_N];
  logic [7:0] hold_nxt [`FSP_HOLD_N];
  logic config_space_select_r, config_space_select_nxt;
  logic erase_r, erase_nxt;
  logic abort_r, abort_nxt;
  logic write_enable_bit_r, write_enable_bit_nxt;
  logic start_r, start_nxt;
  logic [1:0] key_r, key_nxt;
  fsp_state_t state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  fsp_flash_cmd_t cmd_r, cmd_nxt;
  fsp_flash_rd_t rd_r, rd_nxt;
  logic rd_wait_r, rd_wait_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Pointer arithmetic on the low 21 bits only
  function automatic logic [`FSP_PTR_W-1:0] ptr_step(input logic [`FSP_PTR_W-1:0] p,
                                                    input logic dec);
    logic [`FSP_PTR_W-2:0] low;
    low = dec ? p[`FSP_PTR_W-2:0] - 1'b1 : p[`FSP_PTR_W-2:0] + 1'b1;
    ptr_step = {p[`FSP_PTR_W-1], low};
  endfunction : ptr_step

  logic idle;
  logic tbl_op;
  logic [`FSP_PTR_W-1:0] ptr_eff;
  logic [`FSP_PTR_W-1:0] ptr_after;
  logic [7:0] ctrl_view;
  logic wr_ctrl;
  logic start_req;
  logic start_ok;
  logic done;

  always_comb begin
    idle = (state_r == FSP_ST_IDLE);
    tbl_op = idle && (tbl_rd_req || tbl_wr_req);
    ptr_eff = ptr_r;
    ptr_after = ptr_r;
    unique case (fsp_ptr_mode_t'(tbl_mode))
      FSP_PTR_KEEP: begin
        ptr_after = ptr_r;
      end
      FSP_PTR_POST_INC: begin
        ptr_after = ptr_step(ptr_r, 1'b0);
      end
      FSP_PTR_POST_DEC: begin
        ptr_after = ptr_step(ptr_r, 1'b1);
      end
      FSP_PTR_PRE_INC: begin
        ptr_eff = ptr_step(ptr_r, 1'b0);
        ptr_after = ptr_eff;
      end
    endcase
    ctrl_view = 8'h00;
    ctrl_view[`FSP_CTRL_CONFIG_SPACE_SELECT] = config_space_select_r;
    ctrl_view[`FSP_CTRL_ERASE] = erase_r;
    ctrl_view[`FSP_CTRL_ABORT] = abort_r;
    ctrl_view[`FSP_CTRL_WRITE_ENABLE_BIT] = write_enable_bit_r;
    ctrl_view[`FSP_CTRL_START] = start_r;
    wr_ctrl = reg_wr && (reg_addr == `FSP_OFS_CTRL);
    start_req = wr_ctrl && reg_wdata[`FSP_CTRL_START] && !start_r && idle;
    start_ok = start_req && (key_r == 2'h2) && reg_wdata[`FSP_CTRL_WRITE_ENABLE_BIT];
    done = (state_r == FSP_ST_LONG) && (tmr_r == '0);
  end

  // Table pointer
  always_comb begin
    ptr_nxt = ptr_r;
    // Table operations, ignored while the core is stalled
    if (tbl_op) begin
      ptr_nxt = ptr_after;
    end
    // A register write in the same cycle overrides its byte
    if (reg_wr) begin
      unique case (reg_addr)
        `FSP_OFS_PTR_LOW: ptr_nxt[7:0] = reg_wdata;
        `FSP_OFS_PTR_HIGH: ptr_nxt[15:8] = reg_wdata;
        `FSP_OFS_PTR_UPPER: ptr_nxt[`FSP_PTR_W-1:16] = reg_wdata[5:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // Flash read port
  always_comb begin
    rd_nxt = rd_r;
    rd_nxt.en = 1'b0;
    rd_wait_nxt = rd_r.en;
    if (tbl_op && tbl_rd_req) begin
      rd_nxt.en = 1'b1;
      rd_nxt.addr = ptr_eff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_r <= '0;
      rd_wait_r <= 1'b0;
    end else begin
      rd_r <= rd_nxt;
      rd_wait_r <= rd_wait_nxt;
    end
  end

  // Byte latch
  always_comb begin
    latch_nxt = latch_r;
    if (reg_wr && reg_addr == `FSP_OFS_LATCH) begin
      latch_nxt = reg_wdata;
    end
    // Read data returns one cycle after the flash enable
    if (rd_wait_r) begin
      latch_nxt = rd_r.addr[0] ? flash_rdata[15:8] : flash_rdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_r <= `FSP_BYTE_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Holding registers
  always_comb begin
    hold_nxt = hold_r;
    if (tbl_op && !tbl_rd_req) begin
      hold_nxt[ptr_eff[`FSP_HOLD_AW-1:0]] = latch_r;
    end
    if (done && !cmd_r.erase) begin
      for (int i = 0; i < `FSP_HOLD_N; i++) begin
        hold_nxt[i] = `FSP_HOLD_RST;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `FSP_HOLD_N; i++) begin
        hold_r[i] <= `FSP_HOLD_RST;
      end
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // Control bits, unlock key and timed long write
  always_comb begin
    config_space_select_nxt = config_space_select_r;
    erase_nxt = erase_r;
    abort_nxt = abort_r;
    write_enable_bit_nxt = write_enable_bit_r;
    start_nxt = start_r;
    key_nxt = key_r;
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    cmd_nxt = cmd_r;
    cmd_nxt.go = 1'b0;
    if (reg_wr) begin
      key_nxt = 2'h0;
      if (reg_addr == `FSP_OFS_KEY) begin
        if (reg_wdata == `FSP_KEY_FIRST) begin
          key_nxt = 2'h1;
        end else if (reg_wdata == `FSP_KEY_SECOND && key_r == 2'h1) begin
          key_nxt = 2'h2;
        end
      end
    end
    if (wr_ctrl) begin
      config_space_select_nxt = reg_wdata[`FSP_CTRL_CONFIG_SPACE_SELECT];
      erase_nxt = reg_wdata[`FSP_CTRL_ERASE];
      abort_nxt = reg_wdata[`FSP_CTRL_ABORT];
      write_enable_bit_nxt = reg_wdata[`FSP_CTRL_WRITE_ENABLE_BIT];
    end
    if (start_ok) begin
      start_nxt = 1'b1;
      state_nxt = FSP_ST_LONG;
      tmr_nxt = TMR_LAST;
      cmd_nxt.go = 1'b1;
      cmd_nxt.erase = reg_wdata[`FSP_CTRL_ERASE];
      cmd_nxt.cfg = reg_wdata[`FSP_CTRL_CONFIG_SPACE_SELECT];
      if (reg_wdata[`FSP_CTRL_ERASE]) begin
        cmd_nxt.addr = {ptr_r[`FSP_PTR_W-1:`FSP_ROW_LSB],
                        `FSP_ROW_LSB'(0)};
      end else begin
        cmd_nxt.addr = {ptr_r[`FSP_PTR_W-1:`FSP_BLK_LSB],
                        `FSP_BLK_LSB'(0)};
      end
    end else if (start_req) begin
      abort_nxt = 1'b1;
    end
    if (done) begin
      state_nxt = FSP_ST_IDLE;
      start_nxt = 1'b0;
      abort_nxt = 1'b0;
      if (cmd_r.erase) begin
        erase_nxt = 1'b0;
      end
    end else if (state_r == FSP_ST_LONG) begin
      tmr_nxt = tmr_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_space_select_r <= 1'b0;
      erase_r <= 1'b0;
      abort_r <= 1'b0;
      write_enable_bit_r <= 1'b0;
      start_r <= 1'b0;
      key_r <= 2'h0;
      state_r <= FSP_ST_IDLE;
      tmr_r <= '0;
      cmd_r <= '0;
    end else begin
      config_space_select_r <= config_space_select_nxt;
      erase_r <= erase_nxt;
      abort_r <= abort_nxt;
      write_enable_bit_r <= write_enable_bit_nxt;
      start_r <= start_nxt;
      key_r <= key_nxt;
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // Register read data, answered one cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `FSP_OFS_PTR_LOW: rdata_nxt = ptr_r[7:0];
        `FSP_OFS_PTR_HIGH: rdata_nxt = ptr_r[15:8];
        `FSP_OFS_PTR_UPPER: rdata_nxt = {2'h0, ptr_r[`FSP_PTR_W-1:16]};
        `FSP_OFS_LATCH: rdata_nxt = latch_r;
        `FSP_OFS_CTRL: rdata_nxt = ctrl_view;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Holding bytes to the array; an all-ones byte is marked keep
  for (genvar g = 0; g < `FSP_HOLD_N; g++) begin : g_hold
    assign flash_prog_data[8*g +: 8] = hold_r[g];
    assign flash_prog_keep[g] = (hold_r[g] == `FSP_HOLD_RST);
  end

  assign reg_rdata = rdata_r;
  assign cpu_stall = (state_r == FSP_ST_LONG);
  assign flash_rd = rd_r;
  assign flash_cmd = cmd_r;

endmodule : fsp_sequencer
`default_nettype wire

/* File: fsp_seq_chk.sv */
// Port checker for the flash self-program sequencer.
// Bound to every fsp_sequencer; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.svh"
module fsp_seq_chk
  import fsp_pkg::*;
#(
  parameter int LONG_CYCLES = `FSP_LONG_WRITE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [`FSP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core and flash side
  input wire logic tbl_rd_req,
  input wire logic cpu_stall,
  input wire fsp_flash_rd_t flash_rd,
  input wire fsp_flash_cmd_t flash_cmd,
  input wire logic [8*`FSP_HOLD_N-1:0] flash_prog_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  int stall_cnt_r;
  int stall_cnt_nxt;
  always_comb stall_cnt_nxt = cpu_stall ? stall_cnt_r + 1 : 0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stall_cnt_r <= 0;
    else stall_cnt_r <= stall_cnt_nxt;
  end
  sequence s_key(logic [7:0] k);
    reg_wr && reg_addr == 3'h5 && reg_wdata == k;
  endsequence
  sequence s_unlock;
    s_key(8'h55) ##1 !reg_wr ##1 s_key(8'haa) ##1 !reg_wr ##1
      reg_wr && reg_addr == 3'h4 && reg_wdata[2:1] == 2'b11 && !cpu_stall;
  endsequence
  property p_unlock; s_unlock |=> flash_cmd.go && cpu_stall; endproperty
  property p_go_cause;
    flash_cmd.go |-> $past(reg_wr) && $past(reg_addr) == 3'h4 &&
      ($past(reg_wdata) & 8'h16) == {3'h0, flash_cmd.erase, 4'h6};
  endproperty
  property p_row; flash_cmd.go && flash_cmd.erase |-> flash_cmd.addr[5:0] == 6'h0; endproperty
  property p_blk; flash_cmd.go && !flash_cmd.erase |-> flash_cmd.addr[3:0] == 4'h0; endproperty
  property p_stall_len;
    $fell(cpu_stall) |-> stall_cnt_r >= LONG_CYCLES && stall_cnt_r <= LONG_CYCLES + 1;
  endproperty
  property p_hold_clr; $fell(cpu_stall) && !flash_cmd.erase |-> &flash_prog_data; endproperty
  property p_key_rd; reg_rd && reg_addr == 3'h5 |=> reg_rdata == 8'h00; endproperty
  property p_rd_en; tbl_rd_req && !cpu_stall |=> flash_rd.en; endproperty
  property p_rd_stall; tbl_rd_req && cpu_stall |=> !flash_rd.en; endproperty
  a_unlock: assert property (p_unlock) else $error("start sequence ignored");
  a_go_cause: assert property (p_go_cause) else $error("start without enable");
  a_row: assert property (p_row) else $error("erase row not aligned");
  a_blk: assert property (p_blk) else $error("program block not aligned");
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  a_hold_clr: assert property (p_hold_clr) else $error("holding not reset");
  a_key_rd: assert property (p_key_rd) else $error("key read not zero");
  a_rd_en: assert property (p_rd_en) else $error("table read lost");
  a_rd_stall: assert property (p_rd_stall) else $error("read while stalled");
endmodule : fsp_seq_chk
bind fsp_sequencer fsp_seq_chk #(.LONG_CYCLES(LONG_CYCLES)) u_chk (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tbl_rd_req(tbl_rd_req), .cpu_stall(cpu_stall),
  .flash_rd(flash_rd), .flash_cmd(flash_cmd), .flash_prog_data(flash_prog_data));
`default_nettype wire

/* File: fsp_flash_model.sv */
// Flash array stand-in: fixed word pattern per word address.
// Expects the sequencer read port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Read side
  input wire fsp_flash_rd_t flash_rd,
  output logic [15:0] flash_rdata
);
  // Toggles off-cycle so stale data never passes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) flash_rdata <= 16'h0f0f;
    else if (flash_rd.en) flash_rdata <= {flash_rd.addr[8:1] ^ 8'h3c, ~flash_rd.addr[8:1]};
    else flash_rdata <= ~flash_rdata;
  end
endmodule : fsp_flash_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the flash self-program sequencer.
// Uses the flash stand-in and a 20-cycle long write.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb
  import fsp_pkg::*;
();
  logic clk = 0;
  logic reset_n = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic tbl_rd_req = 0;
  logic tbl_wr_req = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic [7:0] reg_rdata;
  logic [7:0] got;
  logic [1:0] tbl_mode = 0;
  logic cpu_stall;
  logic [15:0] flash_rdata;
  logic [15:0] flash_prog_keep;
  logic [127:0] flash_prog_data;
  fsp_flash_rd_t flash_rd;
  fsp_flash_cmd_t flash_cmd;
  int error_cnt = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  fsp_sequencer #(.LONG_CYCLES(20)) dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tbl_rd_req(tbl_rd_req), .tbl_wr_req(tbl_wr_req), .tbl_mode(tbl_mode),
    .cpu_stall(cpu_stall), .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .flash_cmd(flash_cmd), .flash_prog_data(flash_prog_data), .flash_prog_keep(flash_prog_keep));
  fsp_flash_model u_flash (.clk(clk), .reset_n(reset_n), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata));
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd
  task automatic ptr_set(input logic [21:0] p);
    wr(3'h0, p[7:0]);
    wr(3'h1, p[15:8]);
    wr(3'h2, {2'h0, p[21:16]});
  endtask : ptr_set
  task automatic ptr_chk(input logic [21:0] e);
    logic [21:0] p;
    rd(3'h0);
    p[7:0] = got;
    rd(3'h1);
    p[15:8] = got;
    rd(3'h2);
    p[21:16] = got[5:0];
    `CHK("pointer", e, p)
  endtask : ptr_chk
  task automatic tbl(input logic w, input logic [1:0] m);
    @(posedge clk);
    tbl_rd_req <= !w;
    tbl_wr_req <= w;
    tbl_mode <= m;
    @(posedge clk);
    tbl_rd_req <= 1'b0;
    tbl_wr_req <= 1'b0;
    #1;
  endtask : tbl
  task automatic start(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
    wr(3'h5, k1);
    wr(3'h5, k2);
    wr(3'h4, c);
    #1;
  endtask : start
  task automatic wait_idle;
    for (int i = 0; i < 100 && cpu_stall; i++) begin
      @(posedge clk);
      #1;
    end
    if (cpu_stall !== 1'b0) begin
      `CHK("stall end", 1'b0, cpu_stall)
      complete_run();
    end
  endtask : wait_idle
  task automatic t_regs;
    rd(3'h5);
    `CHK("key", 8'h00, got)
    rd(3'h3);
    `CHK("latch", 8'h00, got)
    wr(3'h6, 8'h5a);
    rd(3'h6);
    `CHK("unmapped", 8'h00, got)
    wr(3'h2, 8'hff);
    ptr_chk(22'h3f0000);
    `CHK("upper", 8'h3f, got)
  endtask : t_regs
  task automatic t_read;
    logic [1:0] md[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [21:0] ra[4] = '{22'h3fffff, 22'h200000, 22'h200000, 22'h200000};
    logic [21:0] pa[4] = '{22'h200000, 22'h3fffff, 22'h200000, 22'h200000};
    ptr_set(22'h3fffff);
    for (int i = 0; i < 4; i++) begin
      tbl(1'b0, md[i]);
      `CHK("read addr", ra[i], flash_rd.addr)
      @(posedge clk);
      rd(3'h3);
      `CHK("latch", ra[i][0] ? ra[i][8:1] ^ 8'h3c : ~ra[i][8:1], got)
      ptr_chk(pa[i]);
    end
  endtask : t_read
  task automatic t_prog;
    logic [127:0] hd = ~128'h0;
    hd[47:40] = 8'h12;
    ptr_set(22'h012345);
    wr(3'h3, 8'h12);
    tbl(1'b1, 2'h1);
    wr(3'h3, 8'hff);
    tbl(1'b1, 2'h0);
    `CHK("holding", hd, flash_prog_data)
    `CHK("keep", 16'hffdf, flash_prog_keep)
    `CHK("idle", 1'b0, cpu_stall)
    start(8'h55, 8'haa, 8'h06);
    `CHK("go", 1'b1, flash_cmd.go)
    `CHK("block", {22'h012340, 1'b0}, {flash_cmd.addr, flash_cmd.erase})
    `CHK("cfg", 1'b0, flash_cmd.cfg)
    rd(3'h4);
    `CHK("busy ctrl", 8'h06, got)
    wait_idle();
    `CHK("cleared", ~128'h0, flash_prog_data)
    rd(3'h4);
    `CHK("ctrl", 8'h04, got)
  endtask : t_prog
  task automatic t_erase;
    ptr_set(22'h0012bf);
    wr(3'h4, 8'h14);
    start(8'h55, 8'haa, 8'h16);
    tbl(1'b0, 2'h1);
    `CHK("stalled read", 1'b0, flash_rd.en)
    `CHK("row", {22'h001280, 1'b1}, {flash_cmd.addr, flash_cmd.erase})
    wait_idle();
    rd(3'h4);
    `CHK("ctrl", 8'h04, got)
    ptr_chk(22'h0012bf);
  endtask : t_erase
  task automatic t_refuse;
    logic [23:0] c[4] = '{24'haa5506, 24'h555506, 24'h55aa12, 24'h55aa42};
    logic [7:0] e[4] = '{8'h0c, 8'h0c, 8'h18, 8'h48};
    for (int i = 0; i < 4; i++) begin
      wr(3'h4, 8'h00);
      start(c[i][23:16], c[i][15:8], c[i][7:0]);
      `CHK("refused", 1'b0, cpu_stall)
      rd(3'h4);
      `CHK("abort", e[i], got)
    end
  endtask : t_refuse
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_read();
    t_prog();
    t_erase();
    t_refuse();
    complete_run();
  end
endmodule : tb
`default_nettype wire
